/* File: logic/amp_ctl_port.sv */
// Serial control port of the amplifier: two-wire slave with register bank,
// fault registers and the open-drain clip and fault indicators.
// Assumes an external pull-up on every open-drain line; the bus clock is
// oversampled by clk, so it must stay well below clk / 8.
`timescale 1ns/1ps
`default_nettype none
`include "amp_ctl_regs.svh"

module amp_ctl_port
    import amp_ctl_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_b,
    // Address straps
    input  wire logic       addrStrapHigh,
    input  wire logic       addrStrapLow,
    // Serial bus, open drain: oe low means pulling low
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    output var  logic       sdaOut,
    output var  logic       sdaOe_b,
    // Status from the audio path
    input  wire logic       nearClip,
    input  wire amp_fault_t faultLive,
    input  wire logic [7:0] modIdxCh0,
    input  wire logic [7:0] modIdxCh1,
    // Indicators, open drain
    output var  logic       clipOut,
    output var  logic       clipOe_b,
    output var  logic       faultOut,
    output var  logic       faultOe_b,
    // Control out
    output var  logic       softClipEn
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic sclS;               // Synchronised serial clock
    logic sdaS;               // Synchronised serial data
    logic sclD;               // Previous clock sample
    logic sdaD;               // Previous data sample
    logic strapHiS;           // Synchronised strap high
    logic strapLoS;           // Synchronised strap low
    logic clipS;              // Synchronised clip request
    amp_fault_t faultS;       // Synchronised live faults
    amp_busev_t ev;           // Bus conditions this cycle

    amp_line_sync #(.RESET_LEVEL(1'b1)) uSyncScl (
        .clk(clk), .rst_b(rst_b), .lineIn(sclIn), .lineOut(sclS));
    amp_line_sync #(.RESET_LEVEL(1'b1)) uSyncSda (
        .clk(clk), .rst_b(rst_b), .lineIn(sdaIn), .lineOut(sdaS));
    amp_line_sync #(.RESET_LEVEL(1'b0)) uSyncAh (
        .clk(clk), .rst_b(rst_b), .lineIn(addrStrapHigh),
        .lineOut(strapHiS));
    amp_line_sync #(.RESET_LEVEL(1'b0)) uSyncAl (
        .clk(clk), .rst_b(rst_b), .lineIn(addrStrapLow),
        .lineOut(strapLoS));
    amp_line_sync #(.RESET_LEVEL(1'b0)) uSyncClip (
        .clk(clk), .rst_b(rst_b), .lineIn(nearClip), .lineOut(clipS));

    // One synchroniser per fault source
    genvar gi;
    generate
        for (gi = 0; gi < $bits(amp_fault_t); gi++) begin : gFault
            amp_line_sync #(.RESET_LEVEL(1'b0)) uSyncF (
                .clk(clk), .rst_b(rst_b), .lineIn(faultLive[gi]),
                .lineOut(faultS[gi]));
        end
    endgenerate

    // Edge history, read only from synchronised lines
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclD <= 1'b1;
            sdaD <= 1'b1;
        end else begin
            sclD <= sclS;
            sdaD <= sdaS;
        end
    end

    // Start is data falling and stop data rising while clock high
    always_comb begin
        ev.startSeen = sclS && sclD && sdaD && !sdaS;
        ev.stopSeen  = sclS && sclD && !sdaD && sdaS;
        ev.sclRise   = sclS && !sclD;
        ev.sclFall   = !sclS && sclD;
    end

    // Own address from the straps
    logic [6:0] ownAddr;
    assign ownAddr = {`AMP_DEV_ADDR_BASE, strapHiS, strapLoS};

    // ------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------
    logic [7:0] bank [0:`AMP_BANK_DEPTH-1];  // Read/write locations
    logic [7:0] faultAcc;                    // Accumulated faults
    logic       clrSeen;                     // Last value of clear bit
    logic       bankWe;                      // Write strobe
    logic [6:0] ptr;                         // Register pointer
    logic [7:0] shiftReg;                    // Byte being moved
    logic [7:0] rdData;                      // Byte at the pointer
    logic       wrOk;                        // Pointer is writable

    // Only 0..80 takes writes; the rest is discarded
    assign wrOk = (ptr <= `AMP_RW_LAST);

    // Read mux: status locations come from live logic
    always_comb begin
        if (ptr <= `AMP_RW_LAST) begin
            rdData = bank[ptr];
        end else begin
            case (ptr)
                `AMP_MOD_IDX_CH0: rdData = modIdxCh0;
                `AMP_MOD_IDX_CH1: rdData = modIdxCh1;
                `AMP_FAULT_ACC:   rdData = faultAcc;
                `AMP_FAULT_LIVE:  rdData = faultS;
                default:          rdData = `AMP_BYTE_ZERO;
            endcase
        end
    end

    // Bank writes; memory has no reset, control bits go out via flops
    always_ff @(posedge clk) begin
        if (bankWe && wrOk) begin
            bank[ptr] <= shiftReg;
        end
    end

    // ------------------------------------------------------------
    // Fault history
    // ------------------------------------------------------------
    // Clear happens on any change of the clear bit; a live fault in the
    // same cycle still sets, so no event is lost.
    logic clrBit;
    logic clrToggle;
    assign clrBit    = (bankWe && ptr == `AMP_FLT_CLR_REG)
                       ? shiftReg[`AMP_FLT_CLR_BIT] : clrSeen;
    assign clrToggle = clrBit != clrSeen;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clrSeen  <= 1'b0;
            faultAcc <= `AMP_BYTE_ZERO;
        end else begin
            clrSeen <= clrBit;
            if (clrToggle) begin
                faultAcc <= faultS;
            end else begin
                faultAcc <= faultAcc | faultS;
            end
        end
    end

    // ------------------------------------------------------------
    // Bus protocol state machine
    // ------------------------------------------------------------
    amp_phase_t phase;
    logic [3:0] bitCnt;       // Bits taken in the current byte
    logic       gotPtr;       // Register address byte already taken
    logic       rdMode;       // Current transfer is a read
    logic       masterAck;    // Ack level sampled from the master

    assign bankWe = (phase == AMP_WRX) && ev.sclFall &&
                    bitCnt == `AMP_BITCNT_ACK && gotPtr;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            phase     <= AMP_IDLE;
            bitCnt    <= `AMP_BITCNT_ZERO;
            shiftReg  <= `AMP_BYTE_ZERO;
            gotPtr    <= 1'b0;
            rdMode    <= 1'b0;
            ptr       <= `AMP_PTR_ZERO;
            masterAck <= 1'b0;
        end else if (ev.stopSeen) begin
            phase <= AMP_IDLE;
        end else if (ev.startSeen) begin
            // Start or repeated start; the pointer is kept
            phase  <= AMP_ADDR;
            bitCnt <= `AMP_BITCNT_ZERO;
        end else begin
            case (phase)
                AMP_IDLE: begin
                    bitCnt <= `AMP_BITCNT_ZERO;
                end
                AMP_ADDR, AMP_WRX: begin
                    if (ev.sclRise && bitCnt != `AMP_BITCNT_ACK) begin
                        shiftReg <= {shiftReg[6:0], sdaS};
                        bitCnt   <= bitCnt + 4'h1;
                    end else if (ev.sclFall &&
                                 bitCnt == `AMP_BITCNT_ACK) begin
                        bitCnt <= `AMP_BITCNT_ZERO;
                        if (phase == AMP_ADDR) begin
                            if (shiftReg[7:1] == ownAddr) begin
                                rdMode <= shiftReg[0];
                                phase  <= AMP_AACK;
                            end else begin
                                phase <= AMP_IDLE;
                            end
                        end else begin
                            phase <= AMP_WACK;
                            if (!gotPtr) begin
                                ptr    <= shiftReg[6:0];
                                gotPtr <= 1'b1;
                            end else begin
                                ptr <= ptr + 7'h01;
                            end
                        end
                    end
                end
                AMP_AACK, AMP_WACK: begin
                    // Ack held through the ninth clock high
                    if (ev.sclFall) begin
                        if (rdMode) begin
                            phase    <= AMP_RTX;
                            shiftReg <= rdData;
                        end else begin
                            phase <= AMP_WRX;
                            if (phase == AMP_AACK) begin
                                gotPtr <= 1'b0;
                            end
                        end
                    end
                end
                AMP_RTX: begin
                    if (ev.sclFall) begin
                        if (bitCnt == `AMP_BITCNT_LAST) begin
                            bitCnt <= `AMP_BITCNT_ZERO;
                            phase  <= AMP_RACK;
                            ptr    <= ptr + 7'h01;
                        end else begin
                            bitCnt   <= bitCnt + 4'h1;
                            shiftReg <= {shiftReg[6:0], 1'b1};
                        end
                    end
                end
                AMP_RACK: begin
                    if (ev.sclRise) begin
                        masterAck <= !sdaS;
                    end else if (ev.sclFall) begin
                        if (masterAck) begin
                            phase    <= AMP_RTX;
                            shiftReg <= rdData;
                        end else begin
                            phase <= AMP_IDLE;
                        end
                    end
                end
                default: phase <= AMP_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Data line drive
    // ------------------------------------------------------------
    logic next_sdaLow;
    always_comb begin
        case (phase)
            AMP_AACK, AMP_WACK: next_sdaLow = 1'b1;
            AMP_RTX:            next_sdaLow = !shiftReg[7];
            default:            next_sdaLow = 1'b0;
        endcase
    end

    // Registered drive; one clk late, well inside the low phase
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sdaOut  <= 1'b0;
            sdaOe_b <= 1'b1;
        end else begin
            sdaOut  <= 1'b0;
            sdaOe_b <= !next_sdaLow;
        end
    end

    // ------------------------------------------------------------
    // Indicators and control outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clipOut    <= 1'b0;
            clipOe_b   <= 1'b1;
            faultOut   <= 1'b0;
            faultOe_b  <= 1'b1;
            softClipEn <= 1'b0;
        end else begin
            clipOut    <= 1'b0;
            clipOe_b   <= !clipS;
            faultOut   <= 1'b0;
            faultOe_b  <= !(|faultS);
            if (bankWe && ptr == `AMP_SOFTCLIP_REG) begin
                softClipEn <= shiftReg[`AMP_SOFTCLIP_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_CLIP_PULL: assert property (@(posedge clk) disable iff (!rst_b)
        clipS |=> !clipOe_b && !clipOut)
        else $error("clip indicator not pulled low");
    AST_FAULT_PULL: assert property (@(posedge clk) disable iff (!rst_b)
        (|faultS) |=> !faultOe_b)
        else $error("fault indicator not pulled low");
    AST_ACC_STICKY: assert property (@(posedge clk) disable iff (!rst_b)
        (|faultS && !clrToggle) |=> ((faultAcc & $past(faultS)) ==
                                     $past(faultS)))
        else $error("accumulated fault lost");
    AST_ACC_CLEAR: assert property (@(posedge clk) disable iff (!rst_b)
        clrToggle |=> faultAcc == $past(faultS))
        else $error("fault history not cleared");
    AST_ACK_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
        (phase == AMP_WACK) |=> !sdaOe_b)
        else $error("no acknowledge on data line");
    AST_NOMATCH: assert property (@(posedge clk) disable iff (!rst_b)
        (phase == AMP_ADDR && ev.sclFall && bitCnt == `AMP_BITCNT_ACK &&
         shiftReg[7:1] != ownAddr && !ev.stopSeen && !ev.startSeen)
        |=> phase == AMP_IDLE ##1 sdaOe_b)
        else $error("foreign address answered");
    AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!rst_b)
        ev.stopSeen |=> phase == AMP_IDLE ##1 sdaOe_b)
        else $error("stop did not end transfer");
    AST_RD_INC: assert property (@(posedge clk) disable iff (!rst_b)
        (phase == AMP_RTX && ev.sclFall && bitCnt == `AMP_BITCNT_LAST &&
         !ev.stopSeen && !ev.startSeen) |=> ptr == $past(ptr) + 7'h01)
        else $error("pointer not advanced after read");
    AST_RO_KEEP: assert property (@(posedge clk) disable iff (!rst_b)
        (bankWe && !wrOk) |=> $stable(softClipEn))
        else $error("read-only write changed state");

endmodule : amp_ctl_port

`default_nettype wire

/* File: logic/amp_ctl_regs.svh */
// Constants for the amplifier serial control port: bus address, register
// locations, field positions, reset values and bit counter limits.
// Assumes inclusion from the package and the design modules by bare name.
`ifndef AMP_CTL_REGS_SVH
`define AMP_CTL_REGS_SVH

// Bus address base, upper five bits of the 7-bit address
`define AMP_DEV_ADDR_BASE      5'h08
// Register bank shape
`define AMP_BANK_DEPTH         128
`define AMP_RW_LAST            7'h50
`define AMP_RO_FIRST           7'h60
`define AMP_RO_LAST            7'h7F
// Read-only status locations
`define AMP_MOD_IDX_CH0        7'h62
`define AMP_MOD_IDX_CH1        7'h66
`define AMP_FAULT_ACC          7'h6D
`define AMP_FAULT_LIVE         7'h7C
// Soft clipping enable: location 10, bit 7
`define AMP_SOFTCLIP_REG       7'h0A
`define AMP_SOFTCLIP_BIT       7
// Fault history clear: location 45, bit 2
`define AMP_FLT_CLR_REG        7'h2D
`define AMP_FLT_CLR_BIT        2
// Reset values and bit counter limits
`define AMP_BYTE_ZERO          8'h00
`define AMP_PTR_ZERO           7'h00
`define AMP_BITCNT_ZERO        4'h0
`define AMP_BITCNT_ACK         4'h8
`define AMP_BITCNT_LAST        4'h7

`endif

/* File: logic/amp_ctl_pkg.sv */
// Types shared by the amplifier serial control port modules.
// Assumes amp_ctl_regs.svh is on the include path.
`default_nettype none
`include "amp_ctl_regs.svh"

package amp_ctl_pkg;

    // Bus protocol phases
    typedef enum logic [2:0] {
        AMP_IDLE  = 3'b000,
        AMP_ADDR  = 3'b001,
        AMP_AACK  = 3'b010,
        AMP_WRX   = 3'b011,
        AMP_WACK  = 3'b100,
        AMP_RTX   = 3'b101,
        AMP_RACK  = 3'b110
    } amp_phase_t;

    // Fault vector, bit 7 down to bit 0
    typedef struct packed {
        logic dcProtectionFlag;   // DC protection
        logic pinShort;           // Pin-to-pin short
        logic overTempErr;        // Overtemperature error
        logic overTempWarn;       // Overtemperature warning
        logic underVolt;          // Undervoltage
        logic clockLock;          // Clock-lock fault
        logic overCurrent;        // Overcurrent
        logic capOverVolt;        // Capacitor overvoltage
    } amp_fault_t;

    // Bus conditions found on the sampled lines
    typedef struct packed {
        logic startSeen;
        logic stopSeen;
        logic sclRise;
        logic sclFall;
    } amp_busev_t;

endpackage : amp_ctl_pkg

`default_nettype wire

/* File: logic/amp_line_sync.sv */
// Two-flop synchroniser for one line from outside the clock domain.
// Assumes clk is the system clock; the input may change at any time.
`timescale 1ns/1ps
`default_nettype none

module amp_line_sync
    import amp_ctl_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b1
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Line
    input  wire logic lineIn,
    output var  logic lineOut
);

    // First stage is read only by the second stage
    logic meta;

    // ------------------------------------------------------------
    // Synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            meta    <= RESET_LEVEL;
            lineOut <= RESET_LEVEL;
        end else begin
            meta    <= lineIn;
            lineOut <= meta;
        end
    end

endmodule : amp_line_sync

`default_nettype wire

/* File: bench/amp_bus_master.sv */
// Behavioural two-wire bus master for the amplifier control port.
// Assumes pull-ups on both lines; the bench forms the wired-AND level.
`timescale 1ns/1ps
`default_nettype none

module amp_bus_master (
    // Pacing clock
    input  wire logic clk,
    // Bus lines
    input  wire logic sdaLine,
    output var  logic sclDrv,
    output var  logic sdaRel
);
    // ----------------------------------------------------------------
    // Half bit of 8 clk gives the 160 ns bus clock
    // ----------------------------------------------------------------
    localparam int HALF = 8;

    // Idle bus: both released, clock stands still high between frames
    initial begin
        sclDrv = 1'b1;
        sdaRel = 1'b1;
    end

    // Pace on the falling edge, away from the device's sampling edge
    task automatic pace(input int n);
        repeat (n) @(negedge clk);
    endtask : pace

    // Start or repeated start: data falls while clock is high
    task automatic busStart();
        sdaRel = 1'b1;
        pace(HALF / 2);
        sclDrv = 1'b1;
        pace(HALF);
        sdaRel = 1'b0;
        pace(HALF);
        sclDrv = 1'b0;
        pace(HALF / 2);
    endtask : busStart

    // Stop: data rises while clock is high, bus then left idle
    task automatic busStop();
        sdaRel = 1'b0;
        pace(HALF / 2);
        sclDrv = 1'b1;
        pace(HALF);
        sdaRel = 1'b1;
        pace(HALF);
    endtask : busStop

    // One bit: data set in the low phase, sampled mid high phase
    task automatic bitXfer(input logic tx, output logic rx);
        sdaRel = tx;
        pace(HALF / 2);
        sclDrv = 1'b1;
        pace(HALF / 2);
        rx = sdaLine;
        pace(HALF / 2);
        sclDrv = 1'b0;
        pace(HALF / 2);
    endtask : bitXfer

    // Byte out, MSB first; ack true when the device pulled low
    task automatic wrByte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitXfer(b[i], r);
        end
        bitXfer(1'b1, r);
        ack = ~r;
    endtask : wrByte

    // Byte in; the last byte of a read is left unacknowledged
    task automatic rdByte(input logic ackIt, output logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitXfer(1'b1, r);
            b[i] = r;
        end
        bitXfer(~ackIt, r);
    endtask : rdByte
endmodule : amp_bus_master

`default_nettype wire

/* File: bench/amp_ctl_port_tb.sv */
// Self-checking bench for the amplifier serial control port.
// Assumes the package, the design and amp_bus_master are compiled first.
`timescale 1ns/1ps
`default_nettype none

module amp_ctl_port_tb
    import amp_ctl_pkg::*;
;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic       clk, rst_b;          // System clock, reset
    logic       strapHi, strapLo;    // Address straps
    logic       sclDrv, sdaRel;      // Master drive, 1 = released
    logic       sdaLine;             // Wired-AND data level
    logic       nearClip;            // Clip request
    amp_fault_t faultLive;           // Live fault sources
    logic [7:0] modIdx0, modIdx1;    // Modulation indices
    logic       sdaOut, sdaOe_b, clipOut, clipOe_b;
    logic       faultOut, faultOe_b, softClipEn;
    logic [7:0] rd0, rd1;            // Read results
    logic       ack;                 // Ack seen by the master
    int         failures, nCompared; // Counts

    // Pull-up: low when either party pulls the line
    assign sdaLine = sdaRel & (sdaOe_b | sdaOut);

    amp_ctl_port dut_u (
        .clk(clk), .rst_b(rst_b),
        .addrStrapHigh(strapHi), .addrStrapLow(strapLo),
        .sclIn(sclDrv), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe_b(sdaOe_b),
        .nearClip(nearClip), .faultLive(faultLive),
        .modIdxCh0(modIdx0), .modIdxCh1(modIdx1),
        .clipOut(clipOut), .clipOe_b(clipOe_b),
        .faultOut(faultOut), .faultOe_b(faultOe_b),
        .softClipEn(softClipEn)
    );

    amp_bus_master master_u (
        .clk(clk), .sdaLine(sdaLine), .sclDrv(sclDrv), .sdaRel(sdaRel)
    );

    // ----------------------------------------------------------------
    // Clock and helpers
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compare with case inequality so an unknown never matches
    task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                       input string what);
        nCompared++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // Address byte for the present straps plus direction bit
    function automatic logic [7:0] devByte(input logic rd);
        return {5'h08, strapHi, strapLo, rd};
    endfunction : devByte

    // Write one or two bytes from ptr; every byte must be acked
    task automatic regWrite(input logic [7:0] ptr, input logic [7:0] d0,
                            input logic [7:0] d1, input int n);
        master_u.busStart();
        master_u.wrByte(devByte(1'b0), ack);
        chk({7'h0, ack}, 8'h01, "address ack");
        master_u.wrByte(ptr, ack);
        chk({7'h0, ack}, 8'h01, "pointer ack");
        master_u.wrByte(d0, ack);
        chk({7'h0, ack}, 8'h01, "data ack");
        if (n > 1) begin
            master_u.wrByte(d1, ack);
            chk({7'h0, ack}, 8'h01, "second data ack");
        end
        master_u.busStop();
    endtask : regWrite

    // Set pointer, repeated start, read two bytes, last one not acked
    task automatic regRead(input logic [7:0] ptr, input logic [7:0] e0,
                           input logic [7:0] e1);
        master_u.busStart();
        master_u.wrByte(devByte(1'b0), ack);
        master_u.wrByte(ptr, ack);
        chk({7'h0, ack}, 8'h01, "read pointer ack");
        master_u.busStart();
        master_u.wrByte(devByte(1'b1), ack);
        chk({7'h0, ack}, 8'h01, "read address ack");
        master_u.rdByte(1'b1, rd0);
        master_u.rdByte(1'b0, rd1);
        master_u.busStop();
        chk(rd0, e0, "first byte");
        chk(rd1, e1, "next byte");
        chk({7'h0, sdaOe_b}, 8'h01, "data released");
    endtask : regRead

    // Verdict and end of run
    task automatic end_of_test();
        $display("compared %0d failures %0d", nCompared, failures);
        if (failures == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : end_of_test

    // Hang guard
    initial begin
        repeat (100000) @(posedge clk);
        failures++;
        $display("BAD %0t run limit reached", $time);
        end_of_test();
    end

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        {strapHi, strapLo} = 2'b00;
        nearClip = 1'b0;
        faultLive = 8'h00;
        modIdx0 = 8'h3E;
        modIdx1 = 8'hC1;
        failures = 0;
        nCompared = 0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        repeat (4) @(negedge clk);
        chk({1'b0, sdaOut, clipOut, faultOut, sdaOe_b, clipOe_b,
             faultOe_b, softClipEn}, 8'h0E, "reset outputs");
        // Each strap setting answers at its own address
        for (int s = 0; s < 4; s++) begin
            {strapHi, strapLo} = 2'(s);
            repeat (4) @(negedge clk);
            regWrite(8'h10 + 8'(s), 8'hA0 + 8'(s), 8'h00, 1);
        end
        // A neighbouring address is ignored for the whole frame
        master_u.busStart();
        master_u.wrByte(8'h42, ack);
        chk({7'h0, ack}, 8'h00, "foreign address");
        master_u.wrByte(8'h10, ack);
        master_u.wrByte(8'h00, ack);
        chk({7'h0, ack}, 8'h00, "foreign data");
        master_u.busStop();
        regRead(8'h10, 8'hA0, 8'hA1);
        regRead(8'h12, 8'hA2, 8'hA3);
        // Burst write; soft clipping follows bit 7 of location 10
        regWrite(8'h0A, 8'h80, 8'h5A, 2);
        chk({7'h0, softClipEn}, 8'h01, "soft clip on");
        regRead(8'h0A, 8'h80, 8'h5A);
        // Clearing bit 7 turns soft clipping off again
        regWrite(8'h0A, 8'h7F, 8'h00, 1);
        chk({7'h0, softClipEn}, 8'h00, "soft clip off");
        // Last writable location, then the first locked one
        regWrite(8'h50, 8'h77, 8'h66, 2);
        regRead(8'h50, 8'h77, 8'h00);
        // Status locations ignore writes and show the live index
        regWrite(8'h62, 8'hFF, 8'h00, 1);
        regRead(8'h62, 8'h3E, 8'h00);
        regRead(8'h66, 8'hC1, 8'h00);
        // Clip indicator only ever pulls low
        nearClip = 1'b1;
        repeat (4) @(negedge clk);
        chk({6'h0, clipOe_b, clipOut}, 8'h00, "clip pulled");
        nearClip = 1'b0;
        repeat (4) @(negedge clk);
        chk({6'h0, clipOe_b, clipOut}, 8'h02, "clip released");
        // Live and accumulated faults, then clear by toggling
        regWrite(8'h2D, 8'h00, 8'h00, 1);
        faultLive = 8'hA5;
        repeat (4) @(negedge clk);
        chk({6'h0, faultOe_b, faultOut}, 8'h00, "fault pulled");
        regRead(8'h7C, 8'hA5, 8'h00);
        faultLive = 8'h00;
        repeat (4) @(negedge clk);
        chk({6'h0, faultOe_b, faultOut}, 8'h02, "fault released");
        regRead(8'h6D, 8'hA5, 8'h00);
        regWrite(8'h2D, 8'h04, 8'h00, 1);
        regRead(8'h6D, 8'h00, 8'h00);
        // Toggling back clears again; a fault still live stays shown
        faultLive = 8'h18;
        regWrite(8'h2D, 8'h00, 8'h00, 1);
        regRead(8'h6D, 8'h18, 8'h00);
        faultLive = 8'h00;
        end_of_test();
    end
endmodule : amp_ctl_port_tb

`default_nettype wire
